// File: hw/sgabc_age_timer.sv
`timescale 1ns/1ps
module sgabc_age_timer
  import sgabc_pkg::*;
#(
  parameter logic [AGE_TIMER_W-1:0] P_NORMAL_CYC = AGE_NORMAL_CYC,
  parameter logic [AGE_TIMER_W-1:0] P_FAST_CYC = AGE_FAST_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  sgabc_age_if.timer age
);

  logic [AGE_TIMER_W-1:0] count_reg;
  logic [AGE_TIMER_W-1:0] limit;
  logic tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Period select
  assign limit = age.fast_en ? P_FAST_CYC : P_NORMAL_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Age period counter, cleared while aging is off
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (!age.age_en)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (count_reg >= limit - 1'b1)
    begin
      count_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign age.tick = tick_reg;

endmodule

// File: hw/sgabc_ctrl.sv
`timescale 1ns/1ps
module sgabc_ctrl
  import sgabc_pkg::*;
#(
  parameter logic [AGE_TIMER_W-1:0] P_AGE_NORMAL_CYC = AGE_NORMAL_CYC,
  parameter logic [AGE_TIMER_W-1:0] P_AGE_FAST_CYC = AGE_FAST_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_aging_strap_pin,
  input wire logic i_backoff_strap_pin,
  input wire logic i_collision_drop_strap_pin,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ready,
  input wire logic i_da_valid,
  input wire logic [47:0] i_da,
  output logic o_storm_count,
  input wire logic i_fwd_valid,
  input wire logic i_fwd_crosses_vlan,
  input wire logic i_fwd_known_unicast,
  output logic o_fwd_permit,
  output logic o_fwd_block,
  input wire logic i_contend_valid,
  output logic o_drop_nonfc_src,
  output logic o_pause_fc_src,
  input wire logic i_coll_valid,
  input wire logic [4:0] i_coll_count,
  output logic o_coll_drop,
  output logic o_coll_retry,
  output logic o_age_tick,
  output logic o_aging_active,
  output logic o_fast_age_active,
  output logic o_backoff_aggressive,
  output logic o_bp_carrier_sense,
  output logic o_bp_collision
);

  sgabc_state_t state_reg;
  logic [1:0] settle_reg;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  logic aging_en_reg;
  logic fast_age_reg;
  logic aggr_backoff_reg;
  logic vlan_discard_reg;
  logic mcast_excl_reg;
  logic bp_mode_reg;
  logic fair_mode_reg;
  logic no_exc_drop_reg;
  logic wr_ok;
  logic storm_hit;
  sgabc_age_if age_bus();

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end
    else
    begin
      strap_meta_reg <= {i_collision_drop_strap_pin, i_backoff_strap_pin, i_aging_strap_pin};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture sequence after reset release
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= ST_SETTLE;
      settle_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_SETTLE:
        begin
          settle_reg <= settle_reg + 1'b1;
          if (settle_reg == STRAP_SETTLE_CYC)
          begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  assign wr_ok = i_reg_wr && (state_reg == ST_RUN);
  assign o_reg_ready = (state_reg == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Aging and back-off control register
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aging_en_reg <= RST_AGING_EN;
      fast_age_reg <= RST_FAST_AGE;
      aggr_backoff_reg <= RST_AGGR_BACKOFF;
    end
    else if (state_reg == ST_LOAD)
    begin
      aging_en_reg <= strap_sync_reg[0];
      aggr_backoff_reg <= strap_sync_reg[1];
    end
    else if (wr_ok && i_reg_addr == ADDR_AGING_BACKOFF_CONTROL)
    begin
      aging_en_reg <= i_reg_wdata[BIT_AGING_EN];
      fast_age_reg <= i_reg_wdata[BIT_FAST_AGE];
      aggr_backoff_reg <= i_reg_wdata[BIT_AGGR_BACKOFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding policy control register
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      vlan_discard_reg <= RST_VLAN_MISMATCH_DISCARD;
      mcast_excl_reg <= RST_MCAST_STORM_EXCL;
      bp_mode_reg <= RST_BP_MODE;
      fair_mode_reg <= RST_FAIR_MODE;
      no_exc_drop_reg <= RST_NO_EXC_COLL_DROP;
    end
    else if (state_reg == ST_LOAD)
    begin
      no_exc_drop_reg <= strap_sync_reg[2];
    end
    else if (wr_ok && i_reg_addr == ADDR_FORWARDING_POLICY_CONTROL)
    begin
      vlan_discard_reg <= i_reg_wdata[BIT_VLAN_MISMATCH_DISCARD];
      mcast_excl_reg <= i_reg_wdata[BIT_MCAST_STORM_EXCL];
      bp_mode_reg <= i_reg_wdata[BIT_BP_MODE];
      fair_mode_reg <= i_reg_wdata[BIT_FAIR_MODE];
      no_exc_drop_reg <= i_reg_wdata[BIT_NO_EXC_COLL_DROP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= 8'h00;
      if (i_reg_addr == ADDR_AGING_BACKOFF_CONTROL)
      begin
        o_reg_rdata[BIT_AGING_EN] <= aging_en_reg;
        o_reg_rdata[BIT_FAST_AGE] <= fast_age_reg;
        o_reg_rdata[BIT_AGGR_BACKOFF] <= aggr_backoff_reg;
      end
      else if (i_reg_addr == ADDR_FORWARDING_POLICY_CONTROL)
      begin
        o_reg_rdata[BIT_VLAN_MISMATCH_DISCARD] <= vlan_discard_reg;
        o_reg_rdata[BIT_MCAST_STORM_EXCL] <= mcast_excl_reg;
        o_reg_rdata[BIT_BP_MODE] <= bp_mode_reg;
        o_reg_rdata[BIT_FAIR_MODE] <= fair_mode_reg;
        o_reg_rdata[BIT_NO_EXC_COLL_DROP] <= no_exc_drop_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Age timer
  assign age_bus.age_en = aging_en_reg;
  assign age_bus.fast_en = fast_age_reg;

  sgabc_age_timer #(
    .P_NORMAL_CYC(P_AGE_NORMAL_CYC),
    .P_FAST_CYC(P_AGE_FAST_CYC)
  ) u_age_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .age(age_bus.timer)
  );

  assign o_age_tick = age_bus.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Mode levels to the MAC and aging logic
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_aging_active <= 1'b0;
      o_fast_age_active <= 1'b0;
      o_backoff_aggressive <= 1'b0;
      o_bp_carrier_sense <= 1'b0;
      o_bp_collision <= 1'b0;
    end
    else
    begin
      o_aging_active <= aging_en_reg;
      o_fast_age_active <= aging_en_reg && fast_age_reg;
      o_backoff_aggressive <= aggr_backoff_reg;
      o_bp_carrier_sense <= bp_mode_reg;
      o_bp_collision <= !bp_mode_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-packet decisions, one cycle after the request
  assign storm_hit = (i_da == DA_BROADCAST) || (!mcast_excl_reg && i_da[DA_GROUP_BIT]);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_storm_count <= 1'b0;
      o_fwd_permit <= 1'b0;
      o_fwd_block <= 1'b0;
      o_drop_nonfc_src <= 1'b0;
      o_pause_fc_src <= 1'b0;
      o_coll_drop <= 1'b0;
      o_coll_retry <= 1'b0;
    end
    else
    begin
      o_storm_count <= i_da_valid && storm_hit;
      o_fwd_permit <= i_fwd_valid && (!i_fwd_crosses_vlan
                      || (!vlan_discard_reg && i_fwd_known_unicast));
      o_fwd_block <= i_fwd_valid && i_fwd_crosses_vlan
                     && (vlan_discard_reg || !i_fwd_known_unicast);
      o_drop_nonfc_src <= i_contend_valid && fair_mode_reg;
      o_pause_fc_src <= i_contend_valid && !fair_mode_reg;
      o_coll_drop <= i_coll_valid && (i_coll_count >= EXC_COLL_LIMIT)
                     && !no_exc_drop_reg;
      o_coll_retry <= i_coll_valid && (i_coll_count >= EXC_COLL_LIMIT)
                      && no_exc_drop_reg;
    end
  end

endmodule

// File: shared/sgabc_age_if.sv
`timescale 1ns/1ps
interface sgabc_age_if;
  logic age_en;
  logic fast_en;
  logic tick;

  modport ctrl
  (
    output age_en,
    output fast_en,
    input tick
  );

  modport timer
  (
    input age_en,
    input fast_en,
    output tick
  );
endinterface

// File: shared/sgabc_pkg.sv
package sgabc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_AGING_BACKOFF_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_FORWARDING_POLICY_CONTROL = 8'h04;

  // Aging / back-off control fields
  localparam int BIT_AGING_EN = 2;
  localparam int BIT_FAST_AGE = 1;
  localparam int BIT_AGGR_BACKOFF = 0;

  // Forwarding policy control fields
  localparam int BIT_VLAN_MISMATCH_DISCARD = 7;
  localparam int BIT_MCAST_STORM_EXCL = 6;
  localparam int BIT_BP_MODE = 5;
  localparam int BIT_FAIR_MODE = 4;
  localparam int BIT_NO_EXC_COLL_DROP = 3;

  // Reset values before the straps are taken
  localparam logic RST_AGING_EN = 1'b1;
  localparam logic RST_FAST_AGE = 1'b0;
  localparam logic RST_AGGR_BACKOFF = 1'b0;
  localparam logic RST_VLAN_MISMATCH_DISCARD = 1'b1;
  localparam logic RST_MCAST_STORM_EXCL = 1'b1;
  localparam logic RST_BP_MODE = 1'b1;
  localparam logic RST_FAIR_MODE = 1'b1;
  localparam logic RST_NO_EXC_COLL_DROP = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Packet classification constants
  localparam logic [47:0] DA_BROADCAST = 48'hFFFFFFFFFFFF;
  localparam int DA_GROUP_BIT = 40;
  localparam logic [4:0] EXC_COLL_LIMIT = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int AGE_TIMER_W = 34;
  localparam logic [AGE_TIMER_W-1:0] CLK_HZ = 34'h0_02FAF080;
  localparam logic [AGE_TIMER_W-1:0] AGE_NORMAL_S = 34'h0_0000012C;
  localparam logic [AGE_TIMER_W-1:0] AGE_FAST_US = 34'h0_00000320;
  localparam logic [AGE_TIMER_W-1:0] US_PER_S = 34'h0_000F4240;
  localparam logic [AGE_TIMER_W-1:0] AGE_NORMAL_CYC = AGE_NORMAL_S * CLK_HZ;
  // Divide first so the product stays inside the timer width
  localparam logic [AGE_TIMER_W-1:0] AGE_FAST_CYC = AGE_FAST_US * (CLK_HZ / US_PER_S);

  // Strap capture sequence
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  typedef enum logic [1:0]
  {
    ST_SETTLE,
    ST_LOAD,
    ST_RUN
  } sgabc_state_t;

endpackage

// File: testbench/sgabc_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module sgabc_ctrl_bench
  import sgabc_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] cfg;
    logic [1:0] k;
    logic [47:0] d;
    logic [1:0] e;
  } sgabc_row_t;
  logic i_clk_sys = 0, i_reset_n = 0, i_aging_strap_pin = 0, i_backoff_strap_pin = 0;
  logic i_collision_drop_strap_pin = 0, i_reg_wr = 0, i_reg_rd = 0, i_da_valid = 0;
  logic i_fwd_valid = 0, i_fwd_crosses_vlan = 0, i_fwd_known_unicast = 0;
  logic i_contend_valid = 0, i_coll_valid = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [47:0] i_da = 48'h0;
  logic [4:0] i_coll_count = 5'h00;
  logic o_reg_ready, o_storm_count, o_fwd_permit, o_fwd_block, o_drop_nonfc_src;
  logic o_pause_fc_src, o_coll_drop, o_coll_retry, o_age_tick, o_aging_active;
  logic o_fast_age_active, o_backoff_aggressive, o_bp_carrier_sense, o_bp_collision;
  logic [1:0] got;
  int fails = 0, cmp_count = 0;
  sgabc_row_t rows [14] = '{
    '{8'hF0, 2'h0, DA_BROADCAST, 2'h1}, '{8'hF0, 2'h0, 48'h010000000000, 2'h0},
    '{8'hB0, 2'h0, 48'h010000000000, 2'h1}, '{8'hB0, 2'h0, 48'h1, 2'h0},
    '{8'hF0, 2'h1, 48'h0, 2'h1}, '{8'hF0, 2'h1, 48'h3, 2'h2},
    '{8'h70, 2'h1, 48'h3, 2'h1}, '{8'h70, 2'h1, 48'h1, 2'h2},
    '{8'hF0, 2'h2, 48'h0, 2'h1}, '{8'hE0, 2'h2, 48'h0, 2'h2},
    '{8'hF0, 2'h3, 48'h10, 2'h1}, '{8'hF8, 2'h3, 48'h10, 2'h2},
    '{8'hF8, 2'h3, 48'h1F, 2'h2}, '{8'hF0, 2'h3, 48'hF, 2'h0}};
  sgabc_ctrl #(.P_AGE_NORMAL_CYC(34'h14), .P_AGE_FAST_CYC(34'h5)) dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_aging_strap_pin(i_aging_strap_pin),
    .i_backoff_strap_pin(i_backoff_strap_pin),
    .i_collision_drop_strap_pin(i_collision_drop_strap_pin),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_ready(o_reg_ready),
    .i_da_valid(i_da_valid), .i_da(i_da), .o_storm_count(o_storm_count),
    .i_fwd_valid(i_fwd_valid), .i_fwd_crosses_vlan(i_fwd_crosses_vlan),
    .i_fwd_known_unicast(i_fwd_known_unicast), .o_fwd_permit(o_fwd_permit),
    .o_fwd_block(o_fwd_block), .i_contend_valid(i_contend_valid),
    .o_drop_nonfc_src(o_drop_nonfc_src), .o_pause_fc_src(o_pause_fc_src),
    .i_coll_valid(i_coll_valid), .i_coll_count(i_coll_count), .o_coll_drop(o_coll_drop),
    .o_coll_retry(o_coll_retry), .o_age_tick(o_age_tick), .o_aging_active(o_aging_active),
    .o_fast_age_active(o_fast_age_active), .o_backoff_aggressive(o_backoff_aggressive),
    .o_bp_carrier_sense(o_bp_carrier_sense), .o_bp_collision(o_bp_collision));
  always #10 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1;
    @(negedge i_clk_sys);
    i_reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clk_sys);
    i_reg_rd = 0;
    `CHK(o_reg_rdata, e)
  endtask
  task automatic ticks(input int n, input int e);
    int c;
    c = 0;
    repeat (n)
    begin
      @(negedge i_clk_sys);
      c += (o_age_tick !== 1'b0);
    end
    `CHK(c, e)
  endtask
  task automatic rst(input logic [2:0] s);
    int n;
    {i_collision_drop_strap_pin, i_backoff_strap_pin, i_aging_strap_pin} = s;
    i_reset_n = 0;
    repeat (5) @(negedge i_clk_sys);
    i_reset_n = 1;
    wr(ADDR_FORWARDING_POLICY_CONTROL, 8'h00);
    for (n = 0; n < 20 && o_reg_ready !== 1'b1; n++) @(negedge i_clk_sys);
    if (o_reg_ready !== 1'b1)
    begin
      fails++;
      finish_test;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst(3'b110);
    rd(ADDR_AGING_BACKOFF_CONTROL, 8'h01);
    rd(ADDR_FORWARDING_POLICY_CONTROL, 8'hF8);
    `CHK({o_backoff_aggressive, o_aging_active}, 2'b10)
    ticks(30, 0);
    rst(3'b001);
    rd(ADDR_AGING_BACKOFF_CONTROL, 8'h04);
    rd(ADDR_FORWARDING_POLICY_CONTROL, 8'hF0);
    foreach (rows[i])
    begin
      wr(ADDR_FORWARDING_POLICY_CONTROL, rows[i].cfg);
      i_da = rows[i].d;
      i_fwd_crosses_vlan = rows[i].d[0];
      i_fwd_known_unicast = rows[i].d[1];
      i_coll_count = rows[i].d[4:0];
      {i_coll_valid, i_contend_valid, i_fwd_valid, i_da_valid} = 4'h1 << rows[i].k;
      @(negedge i_clk_sys);
      {i_coll_valid, i_contend_valid, i_fwd_valid, i_da_valid} = 4'h0;
      case (rows[i].k)
        2'h0: got = {1'b0, o_storm_count};
        2'h1: got = {o_fwd_block, o_fwd_permit};
        2'h2: got = {o_pause_fc_src, o_drop_nonfc_src};
        default: got = {o_coll_retry, o_coll_drop};
      endcase
      `CHK(got, rows[i].e)
    end
    wr(ADDR_FORWARDING_POLICY_CONTROL, 8'hD0);
    @(negedge i_clk_sys);
    `CHK({o_bp_carrier_sense, o_bp_collision}, 2'b01)
    wr(ADDR_AGING_BACKOFF_CONTROL, 8'hFF);
    rd(ADDR_AGING_BACKOFF_CONTROL, 8'h07);
    `CHK({o_backoff_aggressive, o_fast_age_active}, 2'b11)
    wr(8'h05, 8'h5A);
    rd(8'h05, 8'h00);
    wr(ADDR_AGING_BACKOFF_CONTROL, 8'h00);
    ticks(30, 0);
    wr(ADDR_AGING_BACKOFF_CONTROL, 8'h04);
    ticks(50, 2);
    wr(ADDR_AGING_BACKOFF_CONTROL, 8'h00);
    wr(ADDR_AGING_BACKOFF_CONTROL, 8'h06);
    ticks(23, 4);
    finish_test;
  end
endmodule

// File: testbench/sgabc_ctrl_monitor.sv
`timescale 1ns/1ps
module sgabc_ctrl_monitor
  import sgabc_pkg::*;
#(
  parameter logic [AGE_TIMER_W-1:0] P_AGE_NORMAL_CYC = AGE_NORMAL_CYC,
  parameter logic [AGE_TIMER_W-1:0] P_AGE_FAST_CYC = AGE_FAST_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_da_valid,
  input wire logic [47:0] i_da,
  input wire logic o_storm_count,
  input wire logic i_fwd_valid,
  input wire logic i_fwd_crosses_vlan,
  input wire logic i_fwd_known_unicast,
  input wire logic o_fwd_permit,
  input wire logic o_fwd_block,
  input wire logic i_contend_valid,
  input wire logic o_drop_nonfc_src,
  input wire logic o_pause_fc_src,
  input wire logic i_coll_valid,
  input wire logic [4:0] i_coll_count,
  input wire logic o_coll_drop,
  input wire logic o_coll_retry,
  input wire logic o_age_tick,
  input wire logic o_aging_active,
  input wire logic o_fast_age_active,
  input wire logic o_bp_carrier_sense,
  input wire logic o_bp_collision
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_storm_bcast: assert property (i_da_valid && i_da == DA_BROADCAST |=> o_storm_count)
    else $error("broadcast not counted");
  a_storm_plain: assert property (i_da_valid && !i_da[DA_GROUP_BIT] |=> !o_storm_count)
    else $error("plain address counted");
  a_fwd_local: assert property (i_fwd_valid && !i_fwd_crosses_vlan
    |=> o_fwd_permit && !o_fwd_block)
    else $error("local forward refused");
  a_fwd_unknown: assert property (i_fwd_valid && i_fwd_crosses_vlan
    && !i_fwd_known_unicast |=> o_fwd_block && !o_fwd_permit)
    else $error("unknown crossed boundary");
  a_contend_one: assert property (i_contend_valid
    |=> o_drop_nonfc_src ^ o_pause_fc_src)
    else $error("contention answer wrong");
  a_coll_low: assert property (i_coll_valid && i_coll_count < EXC_COLL_LIMIT
    |=> !o_coll_drop && !o_coll_retry)
    else $error("action below limit");
  a_coll_high: assert property (i_coll_valid && i_coll_count >= EXC_COLL_LIMIT
    |=> o_coll_drop ^ o_coll_retry)
    else $error("no action at limit");
  a_bp_onehot: assert property ($past(i_reset_n)
    |-> o_bp_carrier_sense ^ o_bp_collision)
    else $error("back pressure style not one hot");
  a_fast_needs_age: assert property (o_fast_age_active |-> o_aging_active)
    else $error("fast age without aging");
  a_age_idle: assert property (!o_aging_active [*3] |-> !o_age_tick)
    else $error("tick while aging off");
  c_tick: cover property (o_age_tick && o_fast_age_active);
  c_block: cover property (o_fwd_block);
  c_retry: cover property (o_coll_retry);
endmodule
bind sgabc_ctrl sgabc_ctrl_monitor #(.P_AGE_NORMAL_CYC(P_AGE_NORMAL_CYC),
  .P_AGE_FAST_CYC(P_AGE_FAST_CYC)) mon (.i_clk_sys, .i_reset_n, .i_da_valid, .i_da,
  .o_storm_count, .i_fwd_valid, .i_fwd_crosses_vlan, .i_fwd_known_unicast, .o_fwd_permit,
  .o_fwd_block, .i_contend_valid, .o_drop_nonfc_src, .o_pause_fc_src, .i_coll_valid,
  .i_coll_count, .o_coll_drop, .o_coll_retry, .o_age_tick, .o_aging_active,
  .o_fast_age_active, .o_bp_carrier_sense, .o_bp_collision);
